// ---- verilog/sdm_pkg.sv ----
// sdm_pkg: register map, field layout, reset values and limits of the
// servo deviation monitor.
// assumes: used as sdm_pkg::name, never imported.
package sdm_pkg;

	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_POS_LIMIT = 8'h04;
	localparam logic [7:0] ADDR_SPD_LIMIT = 8'h08;
	localparam logic [7:0] ADDR_TRQ_LIMIT = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_MASK = 8'h14;
	localparam logic [7:0] ADDR_ALARM_RESET = 8'h18;

	// check select bits
	localparam int SEL_W = 3;
	localparam int SEL_POS = 0;
	localparam int SEL_SPD = 1;
	localparam int SEL_TRQ = 2;
	localparam logic [2:0] SEL_RESET = 3'h3;

	// threshold fields
	localparam int LIM_W = 11;
	localparam logic [10:0] POS_LIMIT_MIN = 11'h001;
	localparam logic [10:0] POS_LIMIT_MAX = 11'h3e8;
	localparam logic [10:0] POS_LIMIT_RESET = 11'h009;
	localparam logic [10:0] SPD_LIMIT_MIN = 11'h001;
	localparam logic [10:0] SPD_LIMIT_MAX = 11'h7d0;
	localparam logic [10:0] SPD_LIMIT_RESET = 11'h064;
	localparam logic [10:0] TRQ_LIMIT_MIN = 11'h001;
	localparam logic [10:0] TRQ_LIMIT_MAX = 11'h3e8;
	localparam logic [10:0] TRQ_LIMIT_RESET = 11'h064;

	// htrans encoding
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// ---- verilog/sdm_limit_clamp.sv ----
// sdm_limit_clamp: clamps a written threshold into its legal range.
// assumes: purely combinational, fed from the bus write data.
`timescale 1ns/1ps
`default_nettype none
module sdm_limit_clamp #(
	parameter int W = 11,
	parameter logic [W-1:0] MIN = '0,
	parameter logic [W-1:0] MAX = '1
) (
	// raw value and clamped result
	input wire logic [31:0] raw,
	output logic [W-1:0] clamped
);
	always_comb
	begin
		if (raw < 32'(MIN))
			clamped = MIN;
		else if (raw > 32'(MAX))
			clamped = MAX;
		else
			clamped = raw[W-1:0];
	end
endmodule
`default_nettype wire

// ---- verilog/sdm_dev_check.sv ----
// sdm_dev_check: registered absolute deviation compare of two signed values.
// assumes: both inputs on hclk, already synchronous.
`timescale 1ns/1ps
`default_nettype none
module sdm_dev_check #(
	parameter int DW = 24,
	parameter int LW = 11
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// operands
	input wire logic enable,
	input wire logic signed [DW-1:0] model_val,
	input wire logic signed [DW-1:0] meas_val,
	input wire logic [LW-1:0] limit,
	// result
	output logic exceed
);
	logic signed [DW:0] diff;
	logic [DW:0] mag;

	always_comb
	begin
		diff = (DW+1)'(model_val) - (DW+1)'(meas_val);
		mag = diff[DW] ? (DW+1)'(-diff) : diff;
	end

	// strictly greater than the threshold trips
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			exceed <= 1'b0;
		else
			exceed <= enable && (mag > (DW+1)'(limit));
	end
endmodule
`default_nettype wire

// ---- verilog/sdm_monitor.sv ----
// sdm_monitor: servo deviation monitor with an AHB-Lite register slave.
// assumes: model and feedback values arrive synchronous to hclk, scaled so
// one count equals one threshold step.
// How it works
// - select bit 0 enables the position check, bit 1 speed, bit 2 torque.
// - after reset the select value is 3: position and speed checks on.
// - position deviation above its threshold raises the position alarm.
// - position threshold is 1 to 1000 steps of 0.01 rev, reset value 9.
// - speed deviation above its threshold raises the speed alarm.
// - speed threshold is 1 to 2000 r/min, reset value 100.
// - torque deviation above its threshold raises the torque alarm.
// - torque threshold is 1 to 1000 percent, reset value 100.
`timescale 1ns/1ps
`default_nettype none
module sdm_monitor #(
	parameter int DW = 24
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// servo loop values
	input wire logic signed [DW-1:0] model_position,
	input wire logic signed [DW-1:0] feedback_position,
	input wire logic signed [DW-1:0] model_speed,
	input wire logic signed [DW-1:0] feedback_speed,
	input wire logic signed [DW-1:0] command_torque,
	input wire logic signed [DW-1:0] feedback_torque,
	// alarm outputs
	output logic position_deviation_alarm,
	output logic speed_deviation_alarm,
	output logic torque_deviation_alarm,
	output logic motor_stop,
	output logic irq
);
	localparam int SW = sdm_pkg::SEL_W;
	localparam int LW = sdm_pkg::LIM_W;

	logic [SW-1:0] deviation_check_select_q;
	logic [LW-1:0] position_deviation_limit_q;
	logic [LW-1:0] speed_deviation_limit_q;
	logic [LW-1:0] torque_deviation_limit_q;
	logic [SW-1:0] status_q;
	logic [SW-1:0] mask_q;
	logic [SW-1:0] alarm_q;
	logic [SW-1:0] exceed;
	logic wr_pend_q;
	logic rd_pend_q;
	logic [7:0] addr_q;
	logic [LW-1:0] pos_clamped;
	logic [LW-1:0] spd_clamped;
	logic [LW-1:0] trq_clamped;
	logic alarm_reset;
	logic [SW-1:0] status_clr;
	logic [31:0] rd_mux;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a[7:2] == off[7:2]);
	endfunction

	// address phase capture, held through a read wait state
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= 8'h00;
		end
		else if (hready)
		begin
			wr_pend_q <= hsel && htrans == sdm_pkg::HTRANS_NONSEQ && hwrite;
			rd_pend_q <= hsel && htrans == sdm_pkg::HTRANS_NONSEQ && !hwrite;
			addr_q <= haddr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			// one wait state per read, so registered read data stands
			// at the edge that ends the data phase
			hreadyout <= !(hready && hsel
				&& htrans == sdm_pkg::HTRANS_NONSEQ && !hwrite);
			hresp <= 1'b0;
		end
	end

	sdm_limit_clamp #(.W(LW), .MIN(sdm_pkg::POS_LIMIT_MIN),
		.MAX(sdm_pkg::POS_LIMIT_MAX)) u_pos_clamp (
		.raw(hwdata),
		.clamped(pos_clamped)
	);
	sdm_limit_clamp #(.W(LW), .MIN(sdm_pkg::SPD_LIMIT_MIN),
		.MAX(sdm_pkg::SPD_LIMIT_MAX)) u_spd_clamp (
		.raw(hwdata),
		.clamped(spd_clamped)
	);
	sdm_limit_clamp #(.W(LW), .MIN(sdm_pkg::TRQ_LIMIT_MIN),
		.MAX(sdm_pkg::TRQ_LIMIT_MAX)) u_trq_clamp (
		.raw(hwdata),
		.clamped(trq_clamped)
	);

	// configuration registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			deviation_check_select_q <= sdm_pkg::SEL_RESET;
			position_deviation_limit_q <= sdm_pkg::POS_LIMIT_RESET;
			speed_deviation_limit_q <= sdm_pkg::SPD_LIMIT_RESET;
			torque_deviation_limit_q <= sdm_pkg::TRQ_LIMIT_RESET;
			mask_q <= 3'h0;
		end
		else if (wr_pend_q)
		begin
			if (hit(addr_q, sdm_pkg::ADDR_CTRL))
				deviation_check_select_q <= hwdata[SW-1:0];
			if (hit(addr_q, sdm_pkg::ADDR_POS_LIMIT))
				position_deviation_limit_q <= pos_clamped;
			if (hit(addr_q, sdm_pkg::ADDR_SPD_LIMIT))
				speed_deviation_limit_q <= spd_clamped;
			if (hit(addr_q, sdm_pkg::ADDR_TRQ_LIMIT))
				torque_deviation_limit_q <= trq_clamped;
			if (hit(addr_q, sdm_pkg::ADDR_MASK))
				mask_q <= hwdata[SW-1:0];
		end
	end

	// deviation compares
	sdm_dev_check #(.DW(DW), .LW(LW)) u_pos_check (
		.hclk(hclk),
		.hresetn(hresetn),
		.enable(deviation_check_select_q[sdm_pkg::SEL_POS]),
		.model_val(model_position),
		.meas_val(feedback_position),
		.limit(position_deviation_limit_q),
		.exceed(exceed[sdm_pkg::SEL_POS])
	);
	sdm_dev_check #(.DW(DW), .LW(LW)) u_spd_check (
		.hclk(hclk),
		.hresetn(hresetn),
		.enable(deviation_check_select_q[sdm_pkg::SEL_SPD]),
		.model_val(model_speed),
		.meas_val(feedback_speed),
		.limit(speed_deviation_limit_q),
		.exceed(exceed[sdm_pkg::SEL_SPD])
	);
	sdm_dev_check #(.DW(DW), .LW(LW)) u_trq_check (
		.hclk(hclk),
		.hresetn(hresetn),
		.enable(deviation_check_select_q[sdm_pkg::SEL_TRQ]),
		.model_val(command_torque),
		.meas_val(feedback_torque),
		.limit(torque_deviation_limit_q),
		.exceed(exceed[sdm_pkg::SEL_TRQ])
	);

	always_comb
	begin
		alarm_reset = wr_pend_q && hit(addr_q, sdm_pkg::ADDR_ALARM_RESET)
			&& hwdata[0];
		status_clr = (wr_pend_q && hit(addr_q, sdm_pkg::ADDR_STATUS)) ?
			hwdata[SW-1:0] : 3'h0;
	end

	// latched alarms, a new trip wins over the reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			alarm_q <= 3'h0;
		else if (alarm_reset)
			alarm_q <= exceed;
		else
			alarm_q <= alarm_q | exceed;
	end

	// sticky status, write one to clear, set wins
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			status_q <= 3'h0;
		else
			status_q <= (status_q & ~status_clr) | exceed;
	end

	// registered alarm and interrupt outputs
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			position_deviation_alarm <= 1'b0;
			speed_deviation_alarm <= 1'b0;
			torque_deviation_alarm <= 1'b0;
			motor_stop <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			position_deviation_alarm <= alarm_q[sdm_pkg::SEL_POS];
			speed_deviation_alarm <= alarm_q[sdm_pkg::SEL_SPD];
			torque_deviation_alarm <= alarm_q[sdm_pkg::SEL_TRQ];
			motor_stop <= |alarm_q;
			irq <= |(status_q & mask_q);
		end
	end

	// read data
	always_comb
	begin
		rd_mux = 32'h0;
		if (hit(addr_q, sdm_pkg::ADDR_CTRL))
			rd_mux = {29'h0, deviation_check_select_q};
		else if (hit(addr_q, sdm_pkg::ADDR_POS_LIMIT))
			rd_mux = {21'h0, position_deviation_limit_q};
		else if (hit(addr_q, sdm_pkg::ADDR_SPD_LIMIT))
			rd_mux = {21'h0, speed_deviation_limit_q};
		else if (hit(addr_q, sdm_pkg::ADDR_TRQ_LIMIT))
			rd_mux = {21'h0, torque_deviation_limit_q};
		else if (hit(addr_q, sdm_pkg::ADDR_STATUS))
			rd_mux = {29'h0, status_q};
		else if (hit(addr_q, sdm_pkg::ADDR_MASK))
			rd_mux = {29'h0, mask_q};
		else if (hit(addr_q, sdm_pkg::ADDR_ALARM_RESET))
			rd_mux = {29'h0, alarm_q};
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0;
		else if (rd_pend_q && !hreadyout)
			hrdata <= rd_mux;
	end
endmodule
`default_nettype wire

// ---- bench/sdm_chk_monitor.sv ----
// sdm_chk: port assertions for sdm_monitor.
// assumes: bound into sdm_monitor, one clock hclk.
`timescale 1ns/1ps
`default_nettype none
module sdm_chk #(
	parameter int DW = 24
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// loop values
	input wire logic signed [DW-1:0] model_position,
	input wire logic signed [DW-1:0] feedback_position,
	input wire logic signed [DW-1:0] model_speed,
	input wire logic signed [DW-1:0] feedback_speed,
	input wire logic signed [DW-1:0] command_torque,
	input wire logic signed [DW-1:0] feedback_torque,
	// alarms
	input wire logic position_deviation_alarm,
	input wire logic speed_deviation_alarm,
	input wire logic torque_deviation_alarm,
	input wire logic motor_stop
);
	logic [2:0] al;
	logic [2:0] age_q;
	logic tk, bp, bs, bt;
	function automatic logic big(input logic signed [DW-1:0] a, b);
		return a - b > 1 || b - a > 1;
	endfunction
	assign al = {torque_deviation_alarm, speed_deviation_alarm,
		position_deviation_alarm};
	assign tk = hsel && hready && htrans == sdm_pkg::HTRANS_NONSEQ;
	assign bp = big(model_position, feedback_position);
	assign bs = big(model_speed, feedback_speed);
	assign bt = big(command_torque, feedback_torque);
	// cycles since the last write was taken
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			age_q <= 3'h7;
		else if (tk && hwrite)
			age_q <= 3'h0;
		else if (age_q != 3'h7)
			age_q <= age_q + 3'h1;
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence dev_s(logic b);
		b ##3 1'b1;
	endsequence
	property cause_p(logic b, logic a);
		$rose(a) |-> $past(b, 3);
	endproperty
	ready_hi_a: assert property (!hreadyout |=> hreadyout)
		else $error("hreadyout low for more than one cycle");
	rd_wait_a: assert property (tk && !hwrite |=> !hreadyout)
		else $error("read taken without a wait state");
	resp_okay_a: assert property (!hresp)
		else $error("hresp not okay");
	pos_cause_a: assert property (cause_p(bp, al[0]))
		else $error("position alarm without deviation");
	spd_cause_a: assert property (cause_p(bs, al[1]))
		else $error("speed alarm without deviation");
	trq_cause_a: assert property (cause_p(bt, al[2]))
		else $error("torque alarm without deviation");
	stop_alarm_a: assert property (motor_stop == |al)
		else $error("motor stop differs from alarms");
	alarm_hold_a: assert property (|($past(al) & ~al) |-> age_q inside {[1:5]})
		else $error("alarm dropped without reset write");
	rdata_load_a: assert property ($changed(hrdata) |-> $past(tk && !hwrite, 2))
		else $error("read data changed without read");
	trip_c: cover property (dev_s(bp) ##0 al[0]);
endmodule
`default_nettype wire

// ---- bench/sdm_loop_model.sv ----
// sdm_loop_model: servo loop values with imposed deviations.
// assumes: deviations driven on hclk by the bench.
`timescale 1ns/1ps
`default_nettype none
module sdm_loop_model (
	// clock
	input wire logic hclk,
	// imposed deviations
	input wire logic signed [23:0] pos_dev,
	input wire logic signed [23:0] spd_dev,
	input wire logic signed [23:0] trq_dev,
	// model and measured values
	output logic signed [23:0] mp,
	output logic signed [23:0] fp,
	output logic signed [23:0] ms,
	output logic signed [23:0] fs,
	output logic signed [23:0] ct,
	output logic signed [23:0] ft
);
	logic signed [23:0] base_q = 24'sh000000;
	// drifting operating point, kept far from wrap
	always_ff @(posedge hclk)
		base_q <= {4'h0, base_q[19:0] + 20'h00123};
	assign fp = base_q;
	assign mp = base_q + pos_dev;
	assign fs = base_q >>> 2;
	assign ms = fs + spd_dev;
	assign ft = base_q >>> 4;
	assign ct = ft + trq_dev;
endmodule
`default_nettype wire

// ---- bench/sdm_monitor_tb.sv ----
// sdm_monitor_tb: register, trip and latch tests of sdm_monitor.
// assumes: sdm_monitor, sdm_loop_model and sdm_chk compiled before.
`timescale 1ns/1ps
`default_nettype none
module sdm_monitor_tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd;
	logic [31:0] rng = 32'h0de07e41;
	logic hready, hresp, pa, sa, ta, stop, irq;
	logic signed [23:0] mp, fp, ms, fs, ct, ft;
	logic signed [23:0] pd = '0, sd = '0, td = '0;
	int errors = 0, checks = 0, cyc = 0;
	int er[8] = '{3, 9, 100, 100, 0, 0, 0, 0};
	int mx[3] = '{1000, 2000, 1000};
	int lim[3];
	always #4 hclk = ~hclk;
	sdm_monitor DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .model_position(mp),
		.feedback_position(fp), .model_speed(ms), .feedback_speed(fs),
		.command_torque(ct), .feedback_torque(ft),
		.position_deviation_alarm(pa), .speed_deviation_alarm(sa),
		.torque_deviation_alarm(ta), .motor_stop(stop), .irq(irq));
	sdm_loop_model LOOP (.hclk(hclk), .pos_dev(pd), .spd_dev(sd),
		.trq_dev(td), .mp(mp), .fp(fp), .ms(ms), .fs(fs), .ct(ct), .ft(ft));
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			errors++;
			$display("Error at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input int i, input int d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= 8'(i * 4);
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= 32'(d);
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rchk(input int i);
		bus(1'b0, i, 0);
		cmp(rd, 32'(er[i]));
	endtask
	task automatic wr(input int i, input int d);
		bus(1'b1, i, d);
		if (i == 0 || i == 5)
			er[i] = d & 7;
		else if (i < 4)
			er[i] = d < 1 ? 1 : d > mx[i - 1] ? mx[i - 1] : d;
		else if (i == 4)
			er[4] &= ~d;
		else if (d & 1)
			er[6] = 0;
	endtask
	task automatic dev(input int m);
		int g;
		g = (xs() & 1) ? 1 : -1;
		@(posedge hclk);
		pd <= 24'(m ? g * (lim[0] + m - 1) : 0);
		sd <= 24'(m ? g * (lim[1] + m - 1) : 0);
		td <= 24'(m ? g * (lim[2] + m - 1) : 0);
	endtask
	task automatic achk(input int e);
		repeat (5) @(posedge hclk);
		cmp({stop, ta, sa, pa}, {e != 0, 3'(e)});
		cmp(irq, (er[4] & er[5]) != 0);
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			print_verdict();
		end
	end
	initial
	begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 8; i++)
			rchk(i);
		$display("reset values done");
		for (int i = 1; i < 4; i++)
		begin
			wr(i, 0);
			rchk(i);
			wr(i, 65535);
			rchk(i);
		end
		$display("limit range done");
		for (int s = 0; s < 8; s++)
		begin
			wr(0, s);
			wr(5, int'(xs() & 32'h7));
			for (int k = 0; k < 3; k++)
			begin
				lim[k] = int'(1 + xs() % mx[k]);
				wr(k + 1, lim[k]);
			end
			dev(1);
			achk(0);
			dev(2);
			er[4] = s;
			er[6] = s;
			achk(s);
			dev(0);
			achk(s);
			rchk(6);
			wr(6, 1);
			achk(0);
			rchk(4);
			wr(4, 7);
			achk(0);
		end
		$display("deviation trips done");
		print_verdict();
	end
endmodule
bind sdm_monitor sdm_chk #(.DW(DW)) u_chk (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.model_position(model_position), .feedback_position(feedback_position),
	.model_speed(model_speed), .feedback_speed(feedback_speed),
	.command_torque(command_torque), .feedback_torque(feedback_torque),
	.position_deviation_alarm(position_deviation_alarm),
	.speed_deviation_alarm(speed_deviation_alarm),
	.torque_deviation_alarm(torque_deviation_alarm),
	.motor_stop(motor_stop));
`default_nettype wire
